/* File: isc_pkg.sv */
// Constants, encodings and state type of the instruction sequence control
package isc_pkg;
   // ==========================================================
   // Word layout
   localparam int W      = 30;
   localparam int AW     = 15;
   localparam int OP_LSB = 24;
   localparam int J_LSB  = 21;
   localparam int K_LSB  = 18;
   localparam int B_LSB  = 15;
   // ==========================================================
   // Fixed low storage locations
   localparam logic [14:0] MC_START  = 15'h0000;
   localparam logic [14:0] RTC_LOC   = 15'h0008;
   localparam logic [14:0] INT_INSTR = 15'h0009;
   localparam logic [14:0] INT_EXIT  = 15'h000A;
   localparam logic [14:0] INT_ENTR  = 15'h000B;
   // ==========================================================
   // Function codes
   localparam logic [5:0] OP_LDA = 6'h08;
   localparam logic [5:0] OP_ADD = 6'h10;
   localparam logic [5:0] OP_SUB = 6'h11;
   localparam logic [5:0] OP_STA = 6'h20;
   localparam logic [5:0] OP_JMP = 6'h31;
   localparam logic [5:0] OP_RJP = 6'h34;
   localparam logic [5:0] OP_RPT = 6'h38;
   localparam logic [5:0] OP_IIB = 6'h3D;
   localparam logic [5:0] OP_IOB = 6'h3E;
   // ==========================================================
   // Operand modes and repeat modifiers
   localparam logic [2:0] K_IMM  = 3'h0;
   localparam logic [2:0] K_LOW  = 3'h2;
   localparam logic [2:0] K_FULL = 3'h3;
   localparam logic [2:0] K_SEXT = 3'h4;
   localparam logic [2:0] K_HIGH = 3'h5;
   localparam logic [2:0] K_LSX  = 3'h6;
   localparam logic [2:0] K_ACC  = 3'h7;
   localparam logic [1:0] RM_INC  = 2'h1;
   localparam logic [1:0] RM_DEC  = 2'h2;
   localparam logic [1:0] RM_BMOD = 2'h3;
   // ==========================================================
   // Storage half-word write masks
   localparam logic [1:0] WM_LOW = 2'h1;
   localparam logic [1:0] WM_ALL = 2'h3;
   // ==========================================================
   // Register port map and control bits
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_PC   = 4'h2;
   localparam logic [3:0] REG_ACC  = 4'h3;
   localparam logic [3:0] REG_B7   = 4'h4;
   localparam int CTRL_RUN  = 0;
   localparam int CTRL_STEP = 1;
   localparam int CTRL_GO   = 2;
   localparam int CTRL_MC   = 3;
   localparam logic RUN_RST = 1'b0;
   // ==========================================================
   // Sequence states
   typedef enum logic [3:0] {
      S_BND, S_A, S_AW, S_B, S_BW, S_C, S_D, S_DW,
      S_E, S_EW, S_EX, S_F, S_FW, S_G, S_GW
   } isc_seq_e;
endpackage

/* File: isc_seq_ctrl.sv */
// Instruction sequence control: main and buffer sequences
`timescale 1ns/1ps
// Function
// - Output-buffer initiate stores whole operand if mode 3, else low half only
// - Then mark channel j output active and go on to next instruction
// - Fetch reads at program counter and bumps it when the read starts
// - Fetch adds selected index register, zero for select 0, to operand address
// - Repeat fetch keeps instruction, no storage read, adds repeat increment
// - Repeat fetch decrements index 7, ends at zero, counter unchanged
// - Operand modes 0, 4, 7 take operand from instruction or accumulator
// - Storage operand moves to exchange register under mode after prior arithmetic
// - Arithmetic without storage; jump swaps program counter and exchange register
// - After arithmetic go to store if a result is written, else fetch
// - Store writes exchange register; address from counter on return jump
// - Channel request served between sequences, main waits till buffer done
// - Buffer read loads address from control word, then word transfer
// - Plain transfer uses index 6 address, moves word, increments index 6
// - Word transfer moves word between channel and held address, then address store
// - Address store increments, writes low half, ends buffer at terminal
// - Fixed low locations: start, channel controls, clock, interrupt words
// - Nonzero repeat state suppresses fetch, advances address, index 7 counts
// - Branch condition of repeated execution ends repeat early
// - Branch ending repeat skips the instruction after the repeated one
// - Count ending repeat runs the following instruction normally
// - Step mode halts after each main sequence, one main sequence per manual step
// - Pending channels served one at a time, channel 7 first
// - Control word holds terminal plus one high, current address low
module isc_seq_ctrl (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Core storage
   output logic             mem_req,
   output logic             mem_we,
   output logic      [1:0]  mem_wmask,
   output logic      [14:0] mem_addr,
   output logic      [29:0] mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [29:0] mem_rdata,
   // Channel registers
   input  wire logic [7:1]  chan_req,
   input  wire logic [7:1]  chan_xfer_req,
   input  wire logic [7:1]  chan_xfer_in,
   input  wire logic [29:0] chan_rdata,
   output logic      [2:0]  chan_sel,
   output logic             chan_ack,
   output logic      [29:0] chan_wdata,
   output logic      [7:1]  chan_in_act,
   output logic      [7:1]  chan_out_act
);
   // ==========================================================
   // State
   typedef struct packed {
      isc_pkg::isc_seq_e st;
      isc_pkg::isc_seq_e nseq;
      logic              run;
      logic              step_mode;
      logic              hold;
      logic              rpt;
      logic              rpt_first;
      logic [1:0]        rmode;
      logic [14:0]       p;
      logic [14:0]       r;
      logic [14:0]       term;
      logic [14:0]       y0;
      logic [29:0]       u;
      logic [29:0]       x;
      logic [29:0]       a;
      logic [7:0][14:0]  b;
      logic [2:0]        ch;
      logic              plain;
      logic [7:0]        in_act;
      logic [7:0]        out_act;
      logic              mem_req;
      logic              mem_we;
      logic [1:0]        wmask;
      logic [14:0]       maddr;
      logic [29:0]       mwd;
      logic              chan_ack;
      logic [29:0]       cwd;
      logic [31:0]       rdata;
   } isc_state_s;

   // Local names of the package states, kept short for the sequencer
   localparam isc_pkg::isc_seq_e S_BND = isc_pkg::S_BND;
   localparam isc_pkg::isc_seq_e S_A   = isc_pkg::S_A;
   localparam isc_pkg::isc_seq_e S_AW  = isc_pkg::S_AW;
   localparam isc_pkg::isc_seq_e S_B   = isc_pkg::S_B;
   localparam isc_pkg::isc_seq_e S_BW  = isc_pkg::S_BW;
   localparam isc_pkg::isc_seq_e S_C   = isc_pkg::S_C;
   localparam isc_pkg::isc_seq_e S_D   = isc_pkg::S_D;
   localparam isc_pkg::isc_seq_e S_DW  = isc_pkg::S_DW;
   localparam isc_pkg::isc_seq_e S_E   = isc_pkg::S_E;
   localparam isc_pkg::isc_seq_e S_EW  = isc_pkg::S_EW;
   localparam isc_pkg::isc_seq_e S_EX  = isc_pkg::S_EX;
   localparam isc_pkg::isc_seq_e S_F   = isc_pkg::S_F;
   localparam isc_pkg::isc_seq_e S_FW  = isc_pkg::S_FW;
   localparam isc_pkg::isc_seq_e S_G   = isc_pkg::S_G;
   localparam isc_pkg::isc_seq_e S_GW  = isc_pkg::S_GW;

   isc_state_s s;
   isc_state_s n;

   logic [5:0]  op;
   logic [2:0]  jf;
   logic [2:0]  kf;
   logic [2:0]  bf;
   logic [14:0] yf;
   logic [7:0]  cand;
   logic [2:0]  sel_ch;
   logic        supp;
   logic        ctrl_wr;

   assign op      = s.u[isc_pkg::OP_LSB +: 6];
   assign jf      = s.u[isc_pkg::J_LSB +: 3];
   assign kf      = s.u[isc_pkg::K_LSB +: 3];
   assign bf      = s.u[isc_pkg::B_LSB +: 3];
   assign yf      = s.u[14:0];
   // Buffer word request counts only on an active channel
   assign cand    = ({chan_req, 1'b0} & (s.in_act | s.out_act)) | {chan_xfer_req, 1'b0};
   assign supp    = s.rpt & ~s.rpt_first;
   assign ctrl_wr = reg_wr & (reg_addr == isc_pkg::REG_CTRL);

   // ==========================================================
   // Helpers
   function automatic logic [2:0] pick_ch(input logic [7:0] m);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (m[i]) begin
            c = 3'(i);
         end
      end
      return c;
   endfunction

   function automatic logic [29:0] kread(input logic [2:0] k, input logic [29:0] d);
      case (k)
         isc_pkg::K_LOW:  kread = {15'h0000, d[14:0]};
         isc_pkg::K_HIGH: kread = {15'h0000, d[29:15]};
         isc_pkg::K_LSX:  kread = {{15{d[14]}}, d[14:0]};
         default:         kread = d;
      endcase
   endfunction

   function automatic logic skipc(input logic [2:0] j, input logic [29:0] v);
      case (j)
         3'h1:    skipc = 1'b1;
         3'h2:    skipc = (v == 30'h00000000);
         3'h3:    skipc = (v != 30'h00000000);
         3'h4:    skipc = ~v[29];
         3'h5:    skipc = v[29];
         default: skipc = 1'b0;
      endcase
   endfunction

   assign sel_ch = pick_ch(cand);

   // ==========================================================
   // Next state
   always_comb begin
      logic [14:0] inc;
      logic [14:0] b7m1;
      logic [14:0] rn;
      logic [29:0] an;
      logic        seq_end;
      inc     = 15'h0000;
      b7m1    = 15'(s.b[7] - 15'h0001);
      rn      = 15'(s.r + 15'h0001);
      an      = s.a;
      seq_end = 1'b0;
      n          = s;
      n.chan_ack = 1'b0;
      n.rdata    = 32'h00000000;
      case (s.st)
         S_BND: begin
            if (|cand) begin
               n.ch    = sel_ch;
               n.plain = cand[sel_ch] & ~(chan_req[sel_ch] & (s.in_act[sel_ch] | s.out_act[sel_ch]));
               n.st    = S_E;
            end else if (s.run && !s.hold) begin
               n.st = s.nseq;
            end
         end
         S_A: begin
            if (supp) begin
               case (s.rmode)
                  isc_pkg::RM_INC:  inc = 15'h0001;
                  isc_pkg::RM_DEC:  inc = 15'h7FFF;
                  isc_pkg::RM_BMOD: inc = s.b[bf];
                  default:          inc = 15'h0000;
               endcase
               n.r       = inc;
               n.u[14:0] = (s.rmode == isc_pkg::RM_BMOD) ? 15'(s.y0 + inc) : 15'(yf + inc);
               n.b[7]    = b7m1;
               if (b7m1 == 15'h0000) begin
                  n.rpt = 1'b0;
               end
               n.nseq  = S_B;
               seq_end = 1'b1;
            end else begin
               n.mem_req = 1'b1;
               n.mem_we  = 1'b0;
               n.maddr   = s.p;
               n.p       = 15'(s.p + 15'h0001);
               n.st      = S_AW;
            end
         end
         S_AW: begin
            if (mem_ack) begin
               n.mem_req = 1'b0;
               n.r       = s.b[mem_rdata[isc_pkg::B_LSB +: 3]];
               n.u       = mem_rdata;
               n.u[14:0] = 15'(mem_rdata[14:0] + s.b[mem_rdata[isc_pkg::B_LSB +: 3]]);
               n.y0      = mem_rdata[14:0];
               if (s.rpt) begin
                  n.rpt_first = 1'b0;
                  n.b[7]      = b7m1;
                  if (b7m1 == 15'h0000) begin
                     n.rpt = 1'b0;
                  end
               end
               n.nseq  = S_B;
               seq_end = 1'b1;
            end
         end
         S_B: begin
            case (kf)
               isc_pkg::K_IMM: begin
                  n.x     = {15'h0000, yf};
                  n.nseq  = S_C;
                  seq_end = 1'b1;
               end
               isc_pkg::K_SEXT: begin
                  n.x     = {{15{yf[14]}}, yf};
                  n.nseq  = S_C;
                  seq_end = 1'b1;
               end
               isc_pkg::K_ACC: begin
                  n.x     = s.a;
                  n.nseq  = S_C;
                  seq_end = 1'b1;
               end
               default: begin
                  n.mem_req = 1'b1;
                  n.mem_we  = 1'b0;
                  n.maddr   = yf;
                  n.st      = S_BW;
               end
            endcase
         end
         S_BW: begin
            // No listed function needs arithmetic ahead of the operand
            if (mem_ack) begin
               n.mem_req = 1'b0;
               n.x       = kread(kf, mem_rdata);
               n.nseq    = S_C;
               seq_end   = 1'b1;
            end
         end
         S_C: begin
            n.nseq = S_A;
            case (op)
               isc_pkg::OP_LDA: an = s.x;
               isc_pkg::OP_ADD: an = 30'(s.a + s.x);
               isc_pkg::OP_SUB: an = 30'(s.a - s.x);
               isc_pkg::OP_STA: begin
                  n.x    = s.a;
                  n.nseq = S_D;
               end
               isc_pkg::OP_JMP: begin
                  n.x = {15'h0000, s.p};
                  n.p = s.x[14:0];
               end
               isc_pkg::OP_RJP: begin
                  n.x    = {15'h0000, s.p};
                  n.p    = s.x[14:0];
                  n.nseq = S_D;
               end
               isc_pkg::OP_RPT: begin
                  n.b[7]      = s.x[14:0];
                  n.rpt       = 1'b1;
                  n.rpt_first = 1'b1;
                  n.rmode     = jf[1:0];
               end
               isc_pkg::OP_IIB, isc_pkg::OP_IOB: n.nseq = S_D;
               default: an = s.a;
            endcase
            n.a = an;
            // Branch test only for accumulator functions
            if ((op == isc_pkg::OP_LDA || op == isc_pkg::OP_ADD || op == isc_pkg::OP_SUB) && skipc(jf, an)) begin
               n.p   = 15'(s.p + 15'h0001);
               n.rpt = 1'b0;
            end
            seq_end = 1'b1;
         end
         S_D: begin
            n.mem_req = 1'b1;
            n.mem_we  = 1'b1;
            n.mwd     = s.x;
            n.wmask   = isc_pkg::WM_ALL;
            n.maddr   = yf;
            if (op == isc_pkg::OP_RJP) begin
               n.maddr = s.p;
               n.wmask = isc_pkg::WM_LOW;
            end else if (op == isc_pkg::OP_IIB || op == isc_pkg::OP_IOB) begin
               n.maddr = {12'h000, jf};
               n.wmask = (kf == isc_pkg::K_FULL) ? isc_pkg::WM_ALL : isc_pkg::WM_LOW;
            end else if (kf == isc_pkg::K_LOW) begin
               n.wmask = isc_pkg::WM_LOW;
            end
            n.st = S_DW;
         end
         S_DW: begin
            if (mem_ack) begin
               n.mem_req = 1'b0;
               n.mem_we  = 1'b0;
               if (op == isc_pkg::OP_RJP) begin
                  n.p = 15'(s.p + 15'h0001);
               end
               if (op == isc_pkg::OP_IOB) begin
                  n.out_act[jf] = 1'b1;
                  n.in_act[jf]  = 1'b0;
               end
               if (op == isc_pkg::OP_IIB) begin
                  n.in_act[jf]  = 1'b1;
                  n.out_act[jf] = 1'b0;
               end
               n.in_act[0]  = 1'b0;
               n.out_act[0] = 1'b0;
               n.nseq       = S_A;
               seq_end      = 1'b1;
            end
         end
         S_E: begin
            n.mem_req = 1'b1;
            if (s.plain) begin
               n.maddr  = s.b[6];
               n.mem_we = chan_xfer_in[s.ch];
               n.mwd    = chan_rdata;
               n.wmask  = isc_pkg::WM_ALL;
            end else begin
               n.maddr  = {12'h000, s.ch};
               n.mem_we = 1'b0;
            end
            n.st = S_EW;
         end
         S_EW: begin
            if (mem_ack) begin
               n.mem_req = 1'b0;
               n.mem_we  = 1'b0;
               if (s.plain) begin
                  if (!s.mem_we) begin
                     n.cwd = mem_rdata;
                  end
                  n.chan_ack = 1'b1;
                  n.st       = S_EX;
               end else begin
                  n.r    = mem_rdata[14:0];
                  n.term = mem_rdata[29:15];
                  n.st   = S_F;
               end
            end
         end
         S_EX: begin
            n.b[6] = 15'(s.b[6] + 15'h0001);
            n.st   = S_BND;
         end
         S_F: begin
            n.mem_req = 1'b1;
            n.maddr   = s.r;
            n.mem_we  = s.in_act[s.ch];
            n.mwd     = chan_rdata;
            n.wmask   = isc_pkg::WM_ALL;
            n.st      = S_FW;
         end
         S_FW: begin
            if (mem_ack) begin
               n.mem_req = 1'b0;
               if (!s.mem_we) begin
                  n.cwd = mem_rdata;
               end
               n.chan_ack = 1'b1;
               n.st       = S_G;
            end
         end
         S_G: begin
            n.r       = rn;
            n.mem_req = 1'b1;
            n.mem_we  = 1'b1;
            n.maddr   = {12'h000, s.ch};
            n.mwd     = {15'h0000, rn};
            n.wmask   = isc_pkg::WM_LOW;
            if (rn == s.term) begin
               n.in_act[s.ch]  = 1'b0;
               n.out_act[s.ch] = 1'b0;
            end
            n.st = S_GW;
         end
         S_GW: begin
            if (mem_ack) begin
               n.mem_req = 1'b0;
               n.mem_we  = 1'b0;
               n.st      = S_BND;
            end
         end
         default: n.st = S_BND;
      endcase
      if (seq_end) begin
         n.st = S_BND;
      end
      // Set by a finished sequence wins over a step in the same cycle
      n.hold = (s.hold & ~(ctrl_wr & reg_wdata[isc_pkg::CTRL_GO])) | (seq_end & s.step_mode);
      if (ctrl_wr) begin
         n.run       = reg_wdata[isc_pkg::CTRL_RUN];
         n.step_mode = reg_wdata[isc_pkg::CTRL_STEP];
         if (reg_wdata[isc_pkg::CTRL_MC]) begin
            n.p       = isc_pkg::MC_START;
            n.st      = S_BND;
            n.nseq    = S_A;
            n.rpt     = 1'b0;
            n.mem_req = 1'b0;
            n.mem_we  = 1'b0;
            n.hold    = 1'b0;
         end
      end
      if (reg_wr && reg_addr == isc_pkg::REG_PC) begin
         n.p = reg_wdata[14:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            isc_pkg::REG_CTRL: n.rdata = {29'h0, s.hold, s.step_mode, s.run};
            isc_pkg::REG_STAT: n.rdata = {20'h0, 4'(s.st), 4'(s.nseq), 2'h0, s.plain, s.rpt};
            isc_pkg::REG_PC:   n.rdata = {17'h0, s.p};
            isc_pkg::REG_ACC:  n.rdata = {2'h0, s.a};
            isc_pkg::REG_B7:   n.rdata = {17'h0, s.b[7]};
            default:           n.rdata = 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s      <= '0;
         s.p    <= isc_pkg::MC_START;
         s.st   <= S_BND;
         s.nseq <= S_A;
         s.run  <= isc_pkg::RUN_RST;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata    = s.rdata;
   assign mem_req      = s.mem_req;
   assign mem_we       = s.mem_we;
   assign mem_wmask    = s.wmask;
   assign mem_addr     = s.maddr;
   assign mem_wdata    = s.mwd;
   assign chan_sel     = s.ch;
   assign chan_ack     = s.chan_ack;
   assign chan_wdata   = s.cwd;
   assign chan_in_act  = s.in_act[7:1];
   assign chan_out_act = s.out_act[7:1];

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_fetch_pc_bump: assert property ((s.st == S_A) && !supp && !reg_wr |=>
      (s.maddr == $past(s.p)) && (s.p == 15'($past(s.p) + 15'h0001)))
      else $error("fetch address or counter bump wrong");
   a_rpt_no_read: assert property ((s.st == S_A) && supp && !reg_wr |=>
      !s.mem_req && (s.st == S_BND) && (s.nseq == S_B))
      else $error("repeat fetch touched storage");
   a_rpt_count_down: assert property ((s.st == S_A) && supp && !reg_wr |=>
      (s.b[7] == 15'($past(s.b[7]) - 15'h0001)) && (s.p == $past(s.p)))
      else $error("repeat count or counter wrong");
   a_imm_no_read: assert property ((s.st == S_B) && (kf == 3'h0 || kf == 3'h4 || kf == 3'h7) && !reg_wr
      |=> !s.mem_req ##1 (s.st != S_BW))
      else $error("immediate operand read storage");
   a_buf_at_bound: assert property ((s.st == S_BND) && (|cand) && !reg_wr |=> (s.st == S_E) ##1 s.mem_req)
      else $error("buffer request not taken at boundary");
   a_buf_priority: assert property ((s.st == S_BND) && (|cand) && !reg_wr |=> s.ch == $past(sel_ch))
      else $error("wrong channel chosen");
   a_iob_half_store: assert property ((s.st == S_D) && (op == isc_pkg::OP_IOB) && (kf != 3'h3) && !reg_wr
      |=> (s.wmask == isc_pkg::WM_LOW) && (s.maddr == {12'h000, $past(jf)}) && s.mem_we)
      else $error("initiate store mask or address wrong");
   a_iob_status_set: assert property ((s.st == S_DW) && mem_ack && (op == isc_pkg::OP_IOB) && (jf != 3'h0)
      && !reg_wr |=> s.out_act[$past(jf)] && !s.in_act[$past(jf)] && (s.nseq == S_A))
      else $error("output buffer status not set");
   a_buf_terminal: assert property ((s.st == S_G) && (15'(s.r + 15'h0001) == s.term) && !reg_wr
      |=> !s.in_act[$past(s.ch)] && !s.out_act[$past(s.ch)] && (s.wmask == isc_pkg::WM_LOW))
      else $error("terminal address did not end buffer");
   a_step_halted: assert property ((s.st == S_BND) && s.hold && (cand == 8'h00) && !reg_wr
      |=> (s.st == S_BND) [*2])
      else $error("step mode did not halt");
endmodule

/* File: isc_mem_model.sv */
// Core storage model answering the sequence control's requests
`timescale 1ns/1ps
module isc_mem_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Request side
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [1:0]  mem_wmask,
   input  wire logic [14:0] mem_addr,
   input  wire logic [29:0] mem_wdata,
   input  wire logic [3:0]  wait_cyc,
   // Answer side
   output logic             mem_ack,
   output logic      [29:0] mem_rdata
);
   logic [29:0] mem [0:127];
   logic [3:0]  cnt;
   // ==========================================================
   // Storage access
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 30'h0;
         cnt       <= 4'h0;
      end else begin
         mem_ack   <= 1'b0;
         // Data lines not valid outside an answer
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            // Slow answers as well as prompt ones
            if (cnt >= wait_cyc) begin
               mem_ack <= 1'b1;
               cnt     <= 4'h0;
               mem_rdata <= mem[mem_addr[6:0]];
               if (mem_we && mem_wmask[0]) mem[mem_addr[6:0]][14:0] <= mem_wdata[14:0];
               if (mem_we && mem_wmask[1]) mem[mem_addr[6:0]][29:15] <= mem_wdata[29:15];
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
   end
endmodule

/* File: isc_seq_ctrl_tb_top.sv */
// Self-checking testbench of the instruction sequence control
`timescale 1ns/1ps
module isc_seq_ctrl_tb_top;
   logic clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [3:0] reg_addr = 4'h0, wait_cyc = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, exp_q[$], chan_q[$];
   logic mem_req, mem_we, mem_ack, chan_ack;
   logic [1:0] mem_wmask;
   logic [14:0] mem_addr;
   logic [29:0] mem_wdata, mem_rdata, chan_rdata = 30'h0, chan_wdata;
   logic [7:1] chan_req = 7'h00, chan_xfer_req = 7'h00, chan_in_act, chan_out_act;
   logic [2:0] chan_sel;
   int num_errors = 0, check_count = 0, n;
   always #2 clk_sys = ~clk_sys;
   isc_seq_ctrl i_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
      .mem_wmask(mem_wmask), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .chan_req(chan_req), .chan_xfer_req(chan_xfer_req), .chan_xfer_in(7'h00),
      .chan_rdata(chan_rdata), .chan_sel(chan_sel), .chan_ack(chan_ack), .chan_wdata(chan_wdata),
      .chan_in_act(chan_in_act), .chan_out_act(chan_out_act));
   isc_mem_model i_mem (.clk_sys(clk_sys), .reset(reset), .mem_req(mem_req), .mem_we(mem_we),
      .mem_wmask(mem_wmask), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cyc(wait_cyc),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // ==========================================================
   // Shared tasks
   task check(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task summarize;
      if (num_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] want);
      @(posedge clk_sys);
      reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(want);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   // ==========================================================
   // Watchers take the oldest note when a result appears
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      if (rd_d) check(reg_rdata, exp_q.pop_front());
      if (chan_ack === 1'b1) check({2'h0, chan_wdata}, chan_q.pop_front());
      // Random channel data and storage wait on every cycle
      chan_rdata <= 30'($urandom);
      wait_cyc   <= 4'($urandom % 4);
   end
   initial begin
      #100000;
      num_errors++;
      summarize();
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'hf577));
      // Program away from the fixed control words
      i_mem.mem[64] = 30'h08000005; i_mem.mem[65] = 30'h3E400020; i_mem.mem[66] = 30'h10000003;
      i_mem.mem[67] = 30'h200C0030; i_mem.mem[68] = 30'h31000044;
      i_mem.mem[2] = {15'h0022, 15'h7FFF};
      i_mem.mem[32] = 30'($urandom); i_mem.mem[33] = 30'($urandom); i_mem.mem[48] = 30'h0;
      i_mem.mem[0] = 30'($urandom); i_mem.mem[1] = 30'($urandom);
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      wr(isc_pkg::REG_PC, 32'h40);
      rd(isc_pkg::REG_PC, 32'h40);
      rd(4'hF, 32'h0);
      wr(isc_pkg::REG_CTRL, 32'h1);
      for (n = 0; n < 2000 && i_mem.mem[48] !== 30'h8; n++) @(posedge clk_sys);
      check({2'h0, i_mem.mem[48]}, 32'h8);
      rd(isc_pkg::REG_ACC, 32'h8);
      check({2'h0, i_mem.mem[2]}, {2'h0, 15'h0022, 15'h0020});
      check({25'h0, chan_out_act}, 32'h2);
      // Two output words while the jump loop keeps running
      for (int w = 0; w < 2; w++) begin
         @(posedge clk_sys);
         chan_req <= 7'h02; chan_q.push_back({2'h0, i_mem.mem[32 + w]});
         n = 0;
         do @(posedge clk_sys); while (chan_ack !== 1'b1 && ++n < 2000);
         chan_req <= 7'h00;
         for (n = 0; n < 2000 && i_mem.mem[2][14:0] !== 15'(33 + w); n++) @(posedge clk_sys);
         check({17'h0, i_mem.mem[2][14:0]}, 32'(33 + w));
      end
      repeat (2) @(posedge clk_sys);
      check({25'h0, chan_out_act}, 32'h0);
      check({2'h0, i_mem.mem[48]}, 32'h8);
      // Plain transfers walk index 6 from zero upward
      for (int w = 0; w < 2; w++) begin
         @(posedge clk_sys);
         chan_xfer_req <= 7'h40; chan_q.push_back({2'h0, i_mem.mem[w]});
         n = 0;
         do @(posedge clk_sys); while (chan_ack !== 1'b1 && ++n < 2000);
         chan_xfer_req <= 7'h00;
         check({31'h0, chan_ack}, 32'h1);
      end
      summarize();
   end
endmodule
